/* core/masq_ctrl.sv */
/*
  Alert and squelch controller of a four-lane pluggable transceiver.
  Assumes the two-wire engine supplies one-cycle read strobes and holds the
  software control bits; lane detectors and pins arrive asynchronously.
*/
`timescale 1ns/100ps
module masq_ctrl #(
  parameter int LANES = masq_pkg::LANES,
  parameter int INIT_CYCLES = 16
) (
  input wire logic CLOCK_IN,
  input wire logic RESETN_IN,
  input wire logic INIT_DONE_IN,
  input wire logic STATUS_READ_IN,
  input wire logic [7:0] STATUS_ADDR_IN,
  input wire logic [7:0] STATUS_DATA_IN,
  input wire logic FLAG_FIELD_READ_IN,
  input wire logic [LANES-1:0] RX_SIGNAL_LOSS_IN,
  input wire logic [LANES*masq_pkg::SWING_WIDTH-1:0] TX_SWING_MVPP_IN,
  input wire logic RX_SQUELCH_DISABLE_IN,
  input wire logic TX_SQUELCH_DISABLE_IN,
  input wire logic TX_OFF_BY_DISABLE_IN,
  input wire logic FAULT_EVENT_IN,
  input wire logic LOW_POWER_PIN_IN,
  input wire logic POWER_OVERRIDE_IN,
  input wire logic POWER_SET_IN,
  output logic MODULE_ALERT_N_OUT,
  output logic MODULE_ALERT_N_OE_OUT,
  output logic DATA_NOT_READY_OUT,
  output logic [LANES-1:0] RX_SQUELCH_OUT,
  output logic [LANES-1:0] TX_SQUELCH_OUT,
  output logic [LANES-1:0] TX_DISABLE_OUT,
  output logic [LANES-1:0] TX_INPUT_LOSS_FLAG_OUT,
  output logic LOW_POWER_OUT
);
  // ==========================================================
  // Input synchronisers
  // ==========================================================
  logic [LANES-1:0] los_s1_q, los_s2_q;
  logic lp_s1_q, lp_s2_q;
  logic init_s1_q, init_s2_q;
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RESETN_IN)
    begin
      los_s1_q <= '0;
      los_s2_q <= '0;
      // The low-power pin idles high, so its stages reset high.
      lp_s1_q <= 1'b1;
      lp_s2_q <= 1'b1;
      init_s1_q <= 1'b0;
      init_s2_q <= 1'b0;
    end
    else
    begin
      los_s1_q <= RX_SIGNAL_LOSS_IN;
      los_s2_q <= los_s1_q;
      lp_s1_q <= LOW_POWER_PIN_IN;
      lp_s2_q <= lp_s1_q;
      init_s1_q <= INIT_DONE_IN;
      init_s2_q <= init_s1_q;
    end
  end

  // ==========================================================
  // Lane squelch
  // ==========================================================
  logic [LANES-1:0] rx_sq_d, rx_sq_q, tx_sq_d, tx_sq_q, tx_dis_d, tx_dis_q;
  logic [LANES-1:0] tx_input_loss_flag_d, tx_input_loss_flag_q;
  logic [LANES-1:0] low_swing;
  logic [LANES-1:0] tx_input_loss_flag_sets;
  always_comb
  begin
    for (int i = 0; i < LANES; i++)
    begin
      low_swing[i] = TX_SWING_MVPP_IN[i*masq_pkg::SWING_WIDTH +: masq_pkg::SWING_WIDTH] < masq_pkg::TX_SWING_MIN;
      rx_sq_d[i] = los_s2_q[i] && !RX_SQUELCH_DISABLE_IN;
      tx_sq_d[i] = low_swing[i] && !TX_SQUELCH_DISABLE_IN && !TX_OFF_BY_DISABLE_IN;
      tx_dis_d[i] = low_swing[i] && !TX_SQUELCH_DISABLE_IN && TX_OFF_BY_DISABLE_IN;
      // Loss flag is sticky until the flag field is read; set wins.
      tx_input_loss_flag_sets[i] = low_swing[i] && !tx_input_loss_flag_q[i];
      tx_input_loss_flag_d[i] = low_swing[i] || (tx_input_loss_flag_q[i] && !FLAG_FIELD_READ_IN);
    end
  end
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RESETN_IN)
    begin
      rx_sq_q <= '0;
      tx_sq_q <= '0;
      tx_dis_q <= '0;
      tx_input_loss_flag_q <= '0;
    end
    else
    begin
      rx_sq_q <= rx_sq_d;
      tx_sq_q <= tx_sq_d;
      tx_dis_q <= tx_dis_d;
      tx_input_loss_flag_q <= tx_input_loss_flag_d;
    end
  end

  // ==========================================================
  // Power mode
  // ==========================================================
  logic lp_d, lp_q;
  always_comb
  begin
    lp_d = POWER_OVERRIDE_IN ? POWER_SET_IN : lp_s2_q;
  end
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RESETN_IN)
      lp_q <= 1'b1;
    else
      lp_q <= lp_d;
  end

  // ==========================================================
  // Alert sequencing
  // ==========================================================
  masq_pkg::masq_state_type st_d, st_q;
  logic alert_d, alert_q, dnr_d, dnr_q, dnr_seen_d, dnr_seen_q;
  logic dnr_read_zero;
  always_comb
  begin
    st_d = st_q;
    alert_d = alert_q;
    dnr_d = dnr_q;
    dnr_seen_d = dnr_seen_q;
    dnr_read_zero = STATUS_READ_IN && (STATUS_ADDR_IN == masq_pkg::STATUS_BYTE_ADDR)
      && !STATUS_DATA_IN[masq_pkg::DATA_NOT_READY_BIT];
    case (st_q)
      masq_pkg::MASQ_BOOT:
      begin
        dnr_d = 1'b1;
        if (init_s2_q)
        begin
          // Completion alert with data-not-ready bit cleared.
          dnr_d = 1'b0;
          alert_d = 1'b1;
          dnr_seen_d = 1'b0;
          st_d = masq_pkg::MASQ_WAIT_DNR;
        end
      end
      masq_pkg::MASQ_WAIT_DNR, masq_pkg::MASQ_WAIT_FLAGS:
      begin
        if (dnr_read_zero)
          dnr_seen_d = 1'b1;
        if ((dnr_seen_q || dnr_read_zero) && FLAG_FIELD_READ_IN)
        begin
          // An event in the release cycle wins.
          alert_d = FAULT_EVENT_IN || (|tx_input_loss_flag_sets);
          st_d = masq_pkg::MASQ_RUN;
        end
        else if (dnr_seen_q || dnr_read_zero)
          st_d = masq_pkg::MASQ_WAIT_FLAGS;
      end
      masq_pkg::MASQ_RUN:
      begin
        // New events reassert; set wins over release.
        if (FAULT_EVENT_IN || (|tx_input_loss_flag_sets))
          alert_d = 1'b1;
        else if (FLAG_FIELD_READ_IN)
          alert_d = 1'b0;
      end
      default:
        st_d = masq_pkg::MASQ_BOOT;
    endcase
  end
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RESETN_IN)
    begin
      st_q <= masq_pkg::MASQ_BOOT;
      alert_q <= 1'b0;
      dnr_q <= 1'b1;
      dnr_seen_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      alert_q <= alert_d;
      dnr_q <= dnr_d;
      dnr_seen_q <= dnr_seen_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // Only ever drives low; high comes from the pull-up.
  assign MODULE_ALERT_N_OUT = 1'b0;
  assign MODULE_ALERT_N_OE_OUT = alert_q;
  assign DATA_NOT_READY_OUT = dnr_q;
  assign RX_SQUELCH_OUT = rx_sq_q;
  assign TX_SQUELCH_OUT = tx_sq_q;
  assign TX_DISABLE_OUT = tx_dis_q;
  assign TX_INPUT_LOSS_FLAG_OUT = tx_input_loss_flag_q;
  assign LOW_POWER_OUT = lp_q;
endmodule : masq_ctrl

/* inc/masq_pkg.sv */
/*
  Package for the module alert and squelch controller: lane count, status
  field positions, transmit swing threshold and reset values.
  Assumes nothing of its surroundings.
*/
package masq_pkg;
  // ==========================================================
  // Lanes and status fields
  // ==========================================================
  localparam int LANES = 4;
  // Byte 2 of the status map, bit 0 is the data-not-ready bit.
  localparam logic [7:0] STATUS_BYTE_ADDR = 8'h02;
  localparam int DATA_NOT_READY_BIT = 0;
  // ==========================================================
  // Transmit input swing threshold
  // ==========================================================
  localparam int TX_SWING_MIN_MVPP = 50;
  localparam int SWING_WIDTH = 12;
  localparam logic [SWING_WIDTH-1:0] TX_SWING_MIN = SWING_WIDTH'(TX_SWING_MIN_MVPP);
  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic POWER_OVERRIDE_RST = 1'b0;
  localparam logic POWER_SET_RST = 1'b0;
  localparam logic SQUELCH_DISABLE_RST = 1'b0;
  // ==========================================================
  // Alert sequencing states
  // ==========================================================
  typedef enum logic [3:0] {
    MASQ_BOOT = 4'h1,
    MASQ_WAIT_DNR = 4'h2,
    MASQ_WAIT_FLAGS = 4'h4,
    MASQ_RUN = 4'h8
  } masq_state_type;
endpackage : masq_pkg

/* bench/masq_ctrl_asserts.sv */
/* Checker on the masq_ctrl ports: alert sequencing, receive squelch, power mode.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/100ps
module masq_ctrl_asserts #(parameter int LANES = masq_pkg::LANES) (
  input wire logic CLOCK_IN,
  input wire logic RESETN_IN,
  input wire logic FLAG_FIELD_READ_IN,
  input wire logic FAULT_EVENT_IN,
  input wire logic [LANES-1:0] RX_SIGNAL_LOSS_IN,
  input wire logic RX_SQUELCH_DISABLE_IN,
  input wire logic POWER_OVERRIDE_IN,
  input wire logic POWER_SET_IN,
  input wire logic MODULE_ALERT_N_OUT,
  input wire logic MODULE_ALERT_N_OE_OUT,
  input wire logic DATA_NOT_READY_OUT,
  input wire logic [LANES-1:0] RX_SQUELCH_OUT,
  input wire logic LOW_POWER_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);
  sequence s_new_fault; FAULT_EVENT_IN && !DATA_NOT_READY_OUT; endsequence
  a_pin_low_only: assert property (MODULE_ALERT_N_OUT == 1'b0)
    else $error("alert driven high");
  a_done_alerts: assert property ($fell(DATA_NOT_READY_OUT) |-> MODULE_ALERT_N_OE_OUT)
    else $error("no done alert");
  a_release_read: assert property ($fell(MODULE_ALERT_N_OE_OUT) |->
    $past(FLAG_FIELD_READ_IN) && !DATA_NOT_READY_OUT)
    else $error("early release");
  a_alert_holds: assert property (MODULE_ALERT_N_OE_OUT && !FLAG_FIELD_READ_IN |=> MODULE_ALERT_N_OE_OUT)
    else $error("alert dropped");
  a_fault_alerts: assert property (s_new_fault |=> MODULE_ALERT_N_OE_OUT)
    else $error("fault not alerted");
  // The receive path is three flops deep, so reset must have been off for those three cycles.
  a_rx_squelch: assert property ($past(RESETN_IN) && $past(RESETN_IN, 2) && $past(RESETN_IN, 3)
    && !$past(RX_SQUELCH_DISABLE_IN) |-> RX_SQUELCH_OUT == $past(RX_SIGNAL_LOSS_IN, 3))
    else $error("rx squelch wrong");
  a_rx_off: assert property ($past(RX_SQUELCH_DISABLE_IN) |-> RX_SQUELCH_OUT == '0)
    else $error("rx squelch on");
  a_power_set: assert property (POWER_OVERRIDE_IN |=> LOW_POWER_OUT == $past(POWER_SET_IN))
    else $error("power mode");
endmodule : masq_ctrl_asserts
bind masq_ctrl masq_ctrl_asserts #(.LANES(LANES)) i_masq_ctrl_asserts (
  .CLOCK_IN(CLOCK_IN),
  .RESETN_IN(RESETN_IN),
  .FLAG_FIELD_READ_IN(FLAG_FIELD_READ_IN),
  .FAULT_EVENT_IN(FAULT_EVENT_IN),
  .RX_SIGNAL_LOSS_IN(RX_SIGNAL_LOSS_IN),
  .RX_SQUELCH_DISABLE_IN(RX_SQUELCH_DISABLE_IN),
  .POWER_OVERRIDE_IN(POWER_OVERRIDE_IN),
  .POWER_SET_IN(POWER_SET_IN),
  .MODULE_ALERT_N_OUT(MODULE_ALERT_N_OUT),
  .MODULE_ALERT_N_OE_OUT(MODULE_ALERT_N_OE_OUT),
  .DATA_NOT_READY_OUT(DATA_NOT_READY_OUT),
  .RX_SQUELCH_OUT(RX_SQUELCH_OUT),
  .LOW_POWER_OUT(LOW_POWER_OUT)
);

/* bench/masq_host_model.sv */
/* Host model: on alert reads power class, status byte 2, then the flag field.
   Assumes strobes are taken on the rising edge. */
`timescale 1ns/100ps
module masq_host_model (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic alert_in,
  input wire logic dnr_in,
  output logic rd_out = 1'b0,
  output logic fr_out = 1'b0,
  output logic [15:0] ad_out = 16'h0000
);
  initial forever
  begin
    @(negedge clk_in);
    if (go_in && alert_in)
    begin
      {rd_out, ad_out} <= {1'b1, 16'h81A5};
      @(negedge clk_in);
      ad_out <= {8'h02, 7'h00, dnr_in};
      @(negedge clk_in);
      {rd_out, fr_out} <= 2'h1;
      @(negedge clk_in);
      {fr_out, ad_out} <= {1'b0, ~ad_out};
    end
  end
endmodule : masq_host_model

/* bench/testbench.sv */
/* Bench for masq_ctrl: reset, alert handshake with the host model, random lanes,
   loss flag clearing and a reset in mid-run.
   Assumes the host model answers alerts once go is set. */
`timescale 1ns/100ps
module testbench;
  localparam int L = masq_pkg::LANES;
  localparam int W = masq_pkg::SWING_WIDTH;
  localparam logic [L-1:0] NIL = '0;
  logic clk = 1'b0, rst_n = 1'b0, done = 1'b0, fault = 1'b0, go = 1'b0, rd, fr, an, oe, dnr, lp;
  logic [5:0] ctl = 6'h00;
  logic [L-1:0] loss = '0, lw, rq, tq, td, flag;
  logic [L*W-1:0] sw = '0;
  logic [15:0] ad;
  logic [31:0] seed = 32'h00000041;
  int err_count = 0, total_checks = 0;
  wire pin = oe ? an : 1'b1;
  initial forever #25 clk = ~clk;
  masq_ctrl #(.LANES(L)) i_masq_ctrl (.CLOCK_IN(clk), .RESETN_IN(rst_n), .INIT_DONE_IN(done), .STATUS_READ_IN(rd),
    .STATUS_ADDR_IN(ad[15:8]), .STATUS_DATA_IN(ad[7:0]), .FLAG_FIELD_READ_IN(fr), .RX_SIGNAL_LOSS_IN(loss),
    .TX_SWING_MVPP_IN(sw), .RX_SQUELCH_DISABLE_IN(ctl[5]), .TX_SQUELCH_DISABLE_IN(ctl[4]),
    .TX_OFF_BY_DISABLE_IN(ctl[3]), .LOW_POWER_PIN_IN(ctl[2]), .POWER_OVERRIDE_IN(ctl[1]), .POWER_SET_IN(ctl[0]),
    .FAULT_EVENT_IN(fault), .MODULE_ALERT_N_OUT(an), .MODULE_ALERT_N_OE_OUT(oe), .DATA_NOT_READY_OUT(dnr),
    .RX_SQUELCH_OUT(rq), .TX_SQUELCH_OUT(tq), .TX_DISABLE_OUT(td), .TX_INPUT_LOSS_FLAG_OUT(flag), .LOW_POWER_OUT(lp));
  masq_host_model i_masq_host_model (.clk_in(clk), .go_in(go), .alert_in(!pin), .dnr_in(dnr), .rd_out(rd),
    .fr_out(fr), .ad_out(ad));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [L-1:0] lowv(input logic [L*W-1:0] s);
    for (int i = 0; i < L; i++)
      lowv[i] = s[i*W +: W] < masq_pkg::TX_SWING_MIN;
  endfunction : lowv
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic wait_oe(input logic v);
    for (int n = 0; n < 99 && oe !== v; n++)
      @(negedge clk);
    chk(oe, v);
    if (oe !== v)
      end_sim();
  endtask : wait_oe
  initial
  begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    chk({oe, dnr, lp, rq, tq, td, flag}, {3'h3, NIL, NIL, NIL, NIL});
    done = 1'b1;
    wait_oe(1'b1);
    chk({pin, dnr}, 2'h0);
    go = 1'b1;
    wait_oe(1'b0);
    fault = 1'b1;
    @(negedge clk);
    fault = 1'b0;
    chk(oe, 1'b1);
    wait_oe(1'b0);
    $display("alert test done");
    for (int k = 0; k < 40; k++)
    begin
      loss = L'(xs());
      ctl = seed[9:4];
      sw = (L*W)'({xs(), xs()});
      sw[(k%L)*W +: W] = 12'h031 + 12'(k[0]);
      lw = lowv(sw);
      repeat (4) @(negedge clk);
      chk(rq, ctl[5] ? NIL : loss);
      chk({tq, td}, {ctl[4] | ctl[3] ? NIL : lw, ctl[4] | !ctl[3] ? NIL : lw});
      chk(flag & lw, lw);
      chk(lp, ctl[1] ? ctl[0] : ctl[2]);
    end
    $display("lane test done");
    sw = '1;
    fault = 1'b1;
    @(negedge clk);
    fault = 1'b0;
    chk(oe, 1'b1);
    wait_oe(1'b0);
    chk(flag, NIL);
    sw[W-1:0] = 12'h031;
    @(negedge clk);
    chk({oe, flag}, {1'b1, L'(1)});
    wait_oe(1'b0);
    chk(flag, L'(1));
    $display("flag test done");
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    chk({oe, dnr, lp, rq, tq, td, flag}, {3'h3, NIL, NIL, NIL, NIL});
    wait_oe(1'b1);
    chk({pin, dnr}, 2'h0);
    wait_oe(1'b0);
    $display("reset test done");
    end_sim();
  end
endmodule : testbench
